// ---- verilog/cmcc_channel.sv ----
// Purpose: Configuration, status and time stamp of one full-CAN message channel.
// Assumes: Protocol engine on the same clock; AXI4-Lite register access.
// Notes: Hardware events win over software writes in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module cmcc_channel (
    input wire logic clk,
    input wire logic srst,
    input wire logic [cmcc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [cmcc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] watch_timer,
    output logic tx_request,
    input wire logic tx_start,
    input wire logic tx_take,
    output logic tx_bit,
    output logic tx_busy,
    input wire logic tx_done,
    input wire logic rx_hdr_valid,
    input wire cmcc_pkg::cmcc_hdr_type rx_hdr,
    output logic rx_accept_valid,
    output logic rx_accept,
    input wire logic rx_frame_ok,
    input wire cmcc_pkg::cmcc_err_type err_event,
    output logic irq
);
    import cmcc_pkg::*;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == ADDR_IDENT) || (a == ADDR_CTRL) || (a == ADDR_STAMP)
            || (a == ADDR_CLR) || (a == ADDR_STAT) || (a == ADDR_MASK)
            || (a == ADDR_IEN);
    endfunction

    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic do_wr;
    logic [31:0] ident_q;
    logic [31:0] mask_q;
    cmcc_ctrl_type ctrl_q;
    logic [31:0] stamp_q;
    logic [31:0] stat_q;
    logic [31:0] ien_q;
    cmcc_hdr_type hdr_q;
    logic [31:0] set_v;
    logic [31:0] clr_v;
    logic [31:0] ctrl_wr;
    logic wr_ident;
    logic wr_ctrl;
    logic wr_mask;
    logic wr_ien;
    logic wr_clr;
    logic rx_ok;
    logic rx_remote;
    logic auto_reply;
    logic match_raw;
    logic match_valid_raw;
    logic [31:0] rd_word;

    // Write channel: address and data taken independently, then applied
    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready = !w_held_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign do_wr = aw_held_q && w_held_q && !bvalid_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= WORD_ZERO;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held_q) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_q) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign wr_ident = do_wr && (awaddr_q == ADDR_IDENT);
    assign wr_ctrl = do_wr && (awaddr_q == ADDR_CTRL);
    assign wr_mask = do_wr && (awaddr_q == ADDR_MASK);
    assign wr_ien = do_wr && (awaddr_q == ADDR_IEN);
    assign wr_clr = do_wr && (awaddr_q == ADDR_CLR);
    assign ctrl_wr = merge_bytes({23'h00_0000, ctrl_q}, wdata_q, wstrb_q);

    // Read channel: one read at a time, data from a register
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_comb begin
        rd_word = WORD_ZERO;
        case (s_axi_araddr)
            ADDR_IDENT: rd_word = ident_q;
            ADDR_CTRL: rd_word = {23'h00_0000, ctrl_q};
            ADDR_STAMP: rd_word = stamp_q;
            ADDR_STAT: rd_word = stat_q;
            ADDR_MASK: rd_word = mask_q;
            ADDR_IEN: rd_word = ien_q;
            default: rd_word = WORD_ZERO;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rvalid_q <= 1'b0;
            rdata_q <= WORD_ZERO;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Identifier and mask words
    always_ff @(posedge clk) begin
        if (srst) begin
            ident_q <= WORD_ZERO;
            mask_q <= WORD_ZERO;
        end else begin
            if (wr_ident) begin
                ident_q <= merge_bytes(ident_q, wdata_q, wstrb_q);
            end
            if (wr_mask) begin
                mask_q <= merge_bytes(mask_q, wdata_q, wstrb_q);
            end
        end
    end

    // Engine side: transmit request, header serialiser, acceptance filter
    assign tx_request = ctrl_q.en && ctrl_q.prod;
    assign rx_accept_valid = match_valid_raw;
    assign rx_accept = match_raw && ctrl_q.en;

    cmcc_tx_header u_tx_header (
        .clk(clk),
        .srst(srst),
        .start(tx_start && tx_request),
        .take(tx_take),
        .ident(ident_q),
        .ide(ctrl_q.ide),
        .dlc(ctrl_q.dlc),
        .tx_bit(tx_bit),
        .busy(tx_busy)
    );

    cmcc_accept_filter u_accept_filter (
        .clk(clk),
        .srst(srst),
        .hdr_valid(rx_hdr_valid),
        .hdr(rx_hdr),
        .ident(ident_q),
        .mask(mask_q),
        .ide(ctrl_q.ide),
        .match_valid(match_valid_raw),
        .match(match_raw)
    );

    // Header of the frame under reception, used when it completes
    always_ff @(posedge clk) begin
        if (srst) begin
            hdr_q <= '0;
        end else if (rx_hdr_valid) begin
            hdr_q <= rx_hdr;
        end
    end

    assign rx_ok = rx_frame_ok && ctrl_q.en;
    assign rx_remote = rx_ok && hdr_q.rtr;
    assign auto_reply = rx_remote && ctrl_q.reply;

    // Control word: software writes, hardware updates win
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= ctrl_wr[8:0];
            end
            if (rx_ok) begin
                ctrl_q.dlc <= hdr_q.dlc;
                if (!ctrl_q.ovw && !auto_reply) begin
                    ctrl_q.en <= 1'b0;
                end
            end
            if (tx_done && ctrl_q.prod) begin
                ctrl_q.prod <= 1'b0;
            end
            if (auto_reply) begin
                ctrl_q.prod <= 1'b1;
            end
        end
    end

    // Time stamp from the watch timer seconds counter
    always_ff @(posedge clk) begin
        if (srst) begin
            stamp_q <= WORD_ZERO;
        end else if ((tx_done && ctrl_q.prod) || (rx_ok && !ctrl_q.prod)) begin
            stamp_q <= watch_timer;
        end
    end

    // Status flags: sticky, set beats clear
    always_comb begin
        set_v = WORD_ZERO;
        set_v[ST_ERR_LO +: 5] = err_event;
        set_v[ST_RECEIVE_DONE_FLAG] = rx_ok;
        set_v[ST_TRANSMIT_DONE_FLAG] = tx_done;
        set_v[ST_REMOTE_FRAME_FLAG] = rx_remote || (tx_done && ident_q[ID_RTR]);
        set_v[ST_LENGTH_MISMATCH_WARNING] = rx_ok && (hdr_q.dlc != ctrl_q.dlc);
        set_v[ST_FILLED] = rx_ok && ctrl_q.ovw;
        set_v[ST_RECEIVE_OVERRUN_FLAG] = rx_ok && ctrl_q.ovw && stat_q[ST_FILLED];
    end

    assign clr_v = wr_clr ? (merge_bytes(WORD_ZERO, wdata_q, wstrb_q) & STAT_MASK)
                          : WORD_ZERO;

    always_ff @(posedge clk) begin
        if (srst) begin
            stat_q <= WORD_ZERO;
        end else begin
            stat_q <= ((stat_q & ~clr_v) | set_v) & STAT_MASK;
        end
    end

    // Interrupt enable and level output
    always_ff @(posedge clk) begin
        if (srst) begin
            ien_q <= WORD_ZERO;
        end else if (wr_ien) begin
            ien_q <= merge_bytes(ien_q, wdata_q, wstrb_q) & IRQ_SRC;
        end
    end

    assign irq = |(stat_q & ien_q & IRQ_SRC);

    chk_dlc_update: assert property (@(posedge clk) disable iff (srst)
        rx_ok |=> ctrl_q.dlc == $past(hdr_q.dlc))
        else $error("received length not stored");
    chk_dlc_warn: assert property (@(posedge clk) disable iff (srst)
        rx_ok && (hdr_q.dlc != ctrl_q.dlc) |=> stat_q[ST_LENGTH_MISMATCH_WARNING])
        else $error("length warning missing");
    chk_prod_clear: assert property (@(posedge clk) disable iff (srst)
        tx_done && ctrl_q.prod && !auto_reply |=> !ctrl_q.prod)
        else $error("producer bit kept after transmission");
    chk_reply_req: assert property (@(posedge clk) disable iff (srst)
        auto_reply |=> tx_request)
        else $error("auto reply not requested");
    chk_normal_disable: assert property (@(posedge clk) disable iff (srst)
        rx_ok && !ctrl_q.ovw && !auto_reply |=> !ctrl_q.en)
        else $error("normal mode channel stayed enabled");
    chk_ovw_keep: assert property (@(posedge clk) disable iff (srst)
        rx_ok && ctrl_q.ovw && !wr_ctrl |=> ctrl_q.en && stat_q[ST_FILLED])
        else $error("overwrite mode channel dropped");
    chk_overrun_set: assert property (@(posedge clk) disable iff (srst)
        rx_ok && ctrl_q.ovw && stat_q[ST_FILLED] |=> stat_q[ST_RECEIVE_OVERRUN_FLAG])
        else $error("overrun not flagged");
    chk_stamp_rx: assert property (@(posedge clk) disable iff (srst)
        rx_ok && !ctrl_q.prod |=> stamp_q == $past(watch_timer))
        else $error("stamp not captured");
    chk_clear_flags: assert property (@(posedge clk) disable iff (srst)
        wr_clr && set_v == WORD_ZERO |=> (stat_q & $past(clr_v)) == WORD_ZERO)
        else $error("status clear ignored");
    chk_set_wins: assert property (@(posedge clk) disable iff (srst)
        wr_clr && set_v[ST_LENGTH_MISMATCH_WARNING] |=> stat_q[ST_LENGTH_MISMATCH_WARNING])
        else $error("event lost against clear");
    chk_disabled_idle: assert property (@(posedge clk) disable iff (srst)
        !ctrl_q.en |-> !tx_request && !rx_accept)
        else $error("disabled channel active");
endmodule
`default_nettype wire

// ---- verilog/cmcc_pkg.sv ----
// Purpose: Shared constants and types of one CAN message channel.
// Assumes: 32-bit AXI4-Lite register bus, byte addresses below.
// Notes: CAN recessive level is logic 1.
package cmcc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_IDENT = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STAMP = 8'h08;
    localparam logic [7:0] ADDR_CLR = 8'h0c;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;
    localparam logic [7:0] ADDR_IEN = 8'h18;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Identifier and mask word layout
    localparam int ID_RTR = 31;
    localparam int ID_RB_HI = 30;
    localparam int ID_RB_LO = 29;
    localparam int ID_BASE_HI = 10;
    localparam int ID_EXT_LO = 11;
    localparam int ID_EXT_HI = 28;
    // Status / clear / enable layout
    localparam int ST_ERR_LO = 0;
    localparam int ST_RECEIVE_DONE_FLAG = 5;
    localparam int ST_TRANSMIT_DONE_FLAG = 6;
    localparam int ST_REMOTE_FRAME_FLAG = 7;
    localparam int ST_LENGTH_MISMATCH_WARNING = 9;
    localparam int ST_FILLED = 10;
    localparam int ST_RECEIVE_OVERRUN_FLAG = 11;
    localparam logic [31:0] STAT_MASK = 32'h0000_0eff;
    localparam logic [31:0] IRQ_SRC = 32'h0000_04ff;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [3:0] DLC_MAX = 4'h8;
    localparam logic [5:0] STD_HDR_LEN = 6'h12;
    localparam logic [5:0] EXT_HDR_LEN = 6'h26;
    localparam logic RECESSIVE = 1'b1;

    typedef struct packed {
        logic ovw;
        logic en;
        logic prod;
        logic reply;
        logic ide;
        logic [3:0] dlc;
    } cmcc_ctrl_type;

    typedef struct packed {
        logic rtr;
        logic [1:0] rb;
        logic ext;
        logic [28:0] id;
        logic [3:0] dlc;
    } cmcc_hdr_type;

    typedef struct packed {
        logic bus;
        logic stuff;
        logic crc;
        logic frame;
        logic ack;
    } cmcc_err_type;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SHIFT = 2'b10
    } cmcc_txst_type;
endpackage

// ---- verilog/cmcc_tx_header.sv ----
// Purpose: Serialises identifier and control field of a channel, MSB first.
// Assumes: Engine pulses take once per bit it consumes.
// Notes: Bit on tx_bit is valid while busy.
`timescale 1ns/1ns
`default_nettype none
module cmcc_tx_header (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic take,
    input wire logic [31:0] ident,
    input wire logic ide,
    input wire logic [3:0] dlc,
    output logic tx_bit,
    output logic busy
);
    import cmcc_pkg::*;
    cmcc_txst_type st_q;
    logic [37:0] sh_q;
    logic [5:0] cnt_q;
    logic [37:0] std_v;
    logic [37:0] ext_v;

    assign std_v = {ident[ID_BASE_HI:0], ident[ID_RTR], ident[ID_RB_HI], ident[ID_RB_LO],
                    dlc, 20'h0_0000};
    assign ext_v = {ident[ID_BASE_HI:0], RECESSIVE, RECESSIVE, ident[ID_EXT_HI:ID_EXT_LO],
                    ident[ID_RTR], ident[ID_RB_HI], ident[ID_RB_LO], dlc};
    assign tx_bit = sh_q[37];
    assign busy = (st_q == TX_SHIFT);

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= TX_IDLE;
            sh_q <= '0;
            cnt_q <= '0;
        end else begin
            case (st_q)
                TX_IDLE: begin
                    if (start) begin
                        st_q <= TX_SHIFT;
                        sh_q <= ide ? ext_v : std_v;
                        cnt_q <= ide ? EXT_HDR_LEN : STD_HDR_LEN;
                    end
                end
                TX_SHIFT: begin
                    if (take) begin
                        sh_q <= {sh_q[36:0], 1'b0};
                        cnt_q <= cnt_q - 6'h01;
                        if (cnt_q == 6'h01) begin
                            st_q <= TX_IDLE;
                        end
                    end
                end
                default: st_q <= TX_IDLE;
            endcase
        end
    end

    chk_std_layout: assert property (@(posedge clk) disable iff (srst)
        (st_q == TX_IDLE) && start && !ide |=> sh_q[37:27] == $past(ident[10:0])
        && sh_q[26] == $past(ident[ID_RTR]) && cnt_q == STD_HDR_LEN)
        else $error("standard header loaded wrong");
    chk_ext_order: assert property (@(posedge clk) disable iff (srst)
        (st_q == TX_IDLE) && start && ide |=> sh_q[37:27] == $past(ident[10:0])
        && sh_q[24:7] == $past(ident[28:11]) && sh_q[5:4] == $past(ident[30:29]))
        else $error("extended header order wrong");
endmodule
`default_nettype wire

// ---- verilog/cmcc_accept_filter.sv ----
// Purpose: Acceptance filter of one channel against a received header.
// Assumes: hdr.id[10:0] holds the first received identifier bits.
// Notes: Result is registered, one cycle after hdr_valid.
`timescale 1ns/1ns
`default_nettype none
module cmcc_accept_filter (
    input wire logic clk,
    input wire logic srst,
    input wire logic hdr_valid,
    input wire cmcc_pkg::cmcc_hdr_type hdr,
    input wire logic [31:0] ident,
    input wire logic [31:0] mask,
    input wire logic ide,
    output logic match_valid,
    output logic match
);
    import cmcc_pkg::*;
    logic base_ok;
    logic ext_ok;
    logic bits_ok;

    assign base_ok = ((hdr.id[10:0] ^ ident[10:0]) & mask[10:0]) == 11'h000;
    assign ext_ok = !ide || (((hdr.id[28:11] ^ ident[28:11]) & mask[28:11]) == 18'h0_0000);
    assign bits_ok = !((hdr.rtr ^ ident[ID_RTR]) & mask[ID_RTR])
        && !((hdr.rb[0] ^ ident[ID_RB_LO]) & mask[ID_RB_LO])
        && !(ide && ((hdr.rb[1] ^ ident[ID_RB_HI]) & mask[ID_RB_HI]));

    always_ff @(posedge clk) begin
        if (srst) begin
            match_valid <= 1'b0;
            match <= 1'b0;
        end else begin
            match_valid <= hdr_valid;
            match <= hdr_valid && (hdr.ext == ide) && base_ok && ext_ok && bits_ok;
        end
    end

    chk_std_filter: assert property (@(posedge clk) disable iff (srst)
        hdr_valid && ((hdr.id[10:0] ^ ident[10:0]) & mask[10:0]) != 11'h000 |=> !match)
        else $error("base identifier mismatch accepted");
    chk_ext_filter: assert property (@(posedge clk) disable iff (srst)
        hdr_valid && ide && ((hdr.id[28:11] ^ ident[28:11]) & mask[28:11]) != 18'h0_0000
        |=> !match)
        else $error("extended identifier mismatch accepted");
endmodule
`default_nettype wire

// ---- test/cmcc_engine_model.sv ----
// Purpose: Protocol engine stand-in facing one message channel.
// Assumes: Same clock as the channel; drives right after rising edges.
// Notes: Header lines are inverted once a frame is over.
`timescale 1ns/1ns
`default_nettype none
module cmcc_engine_model (
    input wire logic clk,
    input wire logic tx_request,
    input wire logic tx_bit,
    input wire logic rx_accept,
    output logic tx_start,
    output logic tx_take,
    output logic tx_done,
    output logic rx_hdr_valid,
    output var cmcc_pkg::cmcc_hdr_type rx_hdr,
    output logic rx_frame_ok,
    output var cmcc_pkg::cmcc_err_type err_event
);
    import cmcc_pkg::*;
    initial begin
        {tx_start, tx_take, tx_done, rx_hdr_valid, rx_frame_ok} = 5'h00;
        rx_hdr = '0;
        err_event = '0;
    end
    // Takes n header bits, first bit lands in bits[n-1]
    task automatic send(input int n, output logic [37:0] bits);
        bits = '0;
        while (!tx_request) @(posedge clk);
        tx_start <= 1'b1;
        @(posedge clk);
        tx_start <= 1'b0;
        @(posedge clk);
        tx_take <= 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk);
            bits[i] = tx_bit;
        end
        tx_take <= 1'b0;
        tx_done <= 1'b1;
        @(posedge clk);
        tx_done <= 1'b0;
    endtask
    // Completes the frame only when the channel accepted it
    task automatic recv(input cmcc_hdr_type h);
        rx_hdr <= h;
        rx_hdr_valid <= 1'b1;
        @(posedge clk);
        rx_hdr_valid <= 1'b0;
        @(posedge clk);
        if (rx_accept) begin
            rx_frame_ok <= 1'b1;
            @(posedge clk);
            rx_frame_ok <= 1'b0;
        end
        @(posedge clk);
        rx_hdr <= ~h;
        @(posedge clk);
    endtask
    task automatic err(input cmcc_err_type e);
        err_event <= e;
        @(posedge clk);
        err_event <= '0;
    endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Purpose: Self-checking bench of one message channel.
// Assumes: Mask bit one means the identifier bit is compared.
// Notes: Read and accept results are checked from queues.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import cmcc_pkg::*;
    logic clk, srst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, wt;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic txr, txs, txk, txb, txy, txd, hv, av, acc, fok;
    cmcc_hdr_type hdr;
    cmcc_err_type ev;
    int mismatches, tests_run;
    logic [33:0] rq[$];
    logic aq[$];
    logic [1:0] bq[$];
    cmcc_channel dut_u (.clk(clk), .srst(srst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .watch_timer(wt), .tx_request(txr), .tx_start(txs),
        .tx_take(txk), .tx_bit(txb), .tx_busy(txy), .tx_done(txd), .rx_hdr_valid(hv),
        .rx_hdr(hdr), .rx_accept_valid(av), .rx_accept(acc), .rx_frame_ok(fok),
        .err_event(ev), .irq(irq));
    cmcc_engine_model eng_u (.clk(clk), .tx_request(txr), .tx_bit(txb),
        .rx_accept(acc), .tx_start(txs), .tx_take(txk), .tx_done(txd),
        .rx_hdr_valid(hv), .rx_hdr(hdr), .rx_frame_ok(fok), .err_event(ev));
    task automatic chk(input string nm, input logic [37:0] s, input logic [37:0] e);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic conclude();
        $display("Checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r = RESP_OKAY);
        bit ad, wd;
        {ad, wd} = 2'b00;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bq.push_back(r);
        while (!(ad && wd)) begin
            @(posedge clk);
            if (awvalid && awready) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] r = RESP_OKAY);
        araddr <= a;
        arvalid <= 1'b1;
        rq.push_back({r, e});
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
    endtask
    task automatic rx(input cmcc_hdr_type h, input logic e);
        aq.push_back(e);
        eng_u.recv(h);
    endtask
    always @(posedge clk) begin
        if (rvalid && rready) chk("rdata", {rresp, rdata}, rq.pop_front());
        if (bvalid && bready) chk("bresp", bresp, bq.pop_front());
        if (av) chk("accept", acc, aq.pop_front());
        if (txk) chk("tx_busy", txy, 1'b1);
    end
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #5_000_000;
        mismatches++;
        conclude();
    end
    initial begin
        logic [37:0] b;
        logic [31:0] id, ie;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb, wt} = '0;
        wstrb = 4'hf;
        {mismatches, tests_run} = 0;
        void'($urandom(32'hf1a10a31));
        srst = 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd(ADDR_CTRL, 0);
        rd(ADDR_IDENT, 0);
        rd(ADDR_STAT, 0);
        rd(8'h1c, 0, RESP_SLVERR);
        wr(8'h1c, 32'hffff_ffff, RESP_SLVERR);
        id = $urandom & 32'h1fff_ffff;
        wr(ADDR_IDENT, id);
        wr(ADDR_CTRL, 32'hc5);
        eng_u.send(18, b);
        chk("std_hdr", b, {20'h0, id[10:0], 3'b000, 4'h5});
        rd(ADDR_CTRL, 32'h85);
        ie = $urandom;
        wt <= $urandom;
        wr(ADDR_IDENT, ie);
        wr(ADDR_CTRL, 32'hd3);
        eng_u.send(38, b);
        chk("ext_hdr", b, {ie[10:0], 2'b11, ie[28:11], ie[31:29], 4'h3});
        rd(ADDR_STAMP, wt);
        rd(ADDR_STAT, {24'h0, ie[31], 7'h40});
        wr(ADDR_CLR, 0);
        rd(ADDR_STAT, {24'h0, ie[31], 7'h40});
        wr(ADDR_CLR, 32'hff);
        eng_u.err('1);
        rd(ADDR_STAT, 32'h1f);
        wr(ADDR_IEN, 32'h1);
        @(posedge clk);
        chk("irq_on", irq, 1'b1);
        wr(ADDR_IEN, 0);
        @(posedge clk);
        chk("irq_masked", irq, 1'b0);
        wr(ADDR_IEN, 32'h1);
        wr(ADDR_CLR, 32'h1f);
        @(posedge clk);
        chk("irq_clr", irq, 1'b0);
        rd(ADDR_STAT, 0);
        wr(ADDR_MASK, 32'hffff_ffff);
        wr(ADDR_IDENT, id);
        wr(ADDR_CTRL, 32'h82);
        wt <= $urandom;
        rx({4'h0, ~id[28:11], id[10:0], 4'h6}, 1'b1);
        rd(ADDR_CTRL, 32'h06);
        rd(ADDR_STAT, 32'h220);
        rd(ADDR_STAMP, wt);
        rx({4'h0, id[28:0], 4'h2}, 1'b0);
        wr(ADDR_CTRL, 32'h82);
        rx({4'h0, id[28:4], ~id[3], id[2:0], 4'h2}, 1'b0);
        wr(ADDR_CLR, 32'h220);
        rd(ADDR_STAT, 0);
        wr(ADDR_IDENT, ie & 32'h1fff_ffff);
        wr(ADDR_CTRL, 32'h198);
        rx({4'h1, ie[28:21], ~ie[20], ie[19:0], 4'h8}, 1'b0);
        wr(ADDR_MASK, 32'hffef_ffff);
        rx({4'h1, ie[28:21], ~ie[20], ie[19:0], 4'h8}, 1'b1);
        rx({4'h1, ie[28:0], 4'h8}, 1'b1);
        rd(ADDR_CTRL, 32'h198);
        rd(ADDR_STAT, 32'hc20);
        wr(ADDR_CLR, 32'hc00);
        rd(ADDR_STAT, 32'h20);
        wr(ADDR_CLR, 32'hfff);
        wr(ADDR_MASK, 32'h7fff_ffff);
        wr(ADDR_IDENT, id);
        wr(ADDR_CTRL, 32'ha2);
        rx({4'h8, id[28:0], 4'h2}, 1'b1);
        rd(ADDR_CTRL, 32'he2);
        rd(ADDR_STAT, 32'ha0);
        // Clear lands in the very cycle of the frame's completion
        fork
            rx({4'h0, id[28:0], 4'h7}, 1'b1);
            begin
                @(posedge clk);
                wr(ADDR_CLR, 32'h2a0);
            end
        join
        rd(ADDR_STAT, 32'h220);
        rd(ADDR_CTRL, 32'h67);
        wstrb <= 4'h1;
        wr(ADDR_MASK, 32'h1234_5612);
        wstrb <= 4'hf;
        rd(ADDR_MASK, 32'h7fff_ff12);
        @(posedge clk);
        chk("queues_empty", aq.size() + rq.size() + bq.size(), 0);
        conclude();
    end
endmodule
`default_nettype wire
